/* File: bmc_ctrl.v */
// calibration, discharge hand-over and mode pin control with axi4-lite registers
// Summary of operation
// R01: calibration ends on loss, fault, alarm, host clear
// R02: removed calibrated battery hands over to requester
// R03: finished discharge requests a charge cycle
// R04: strap low, bus supply low: indication mode
// R05: status low charging, high absent, blink done
// R06: alert pin shows first battery status
// R07: blink from scl; scl high means no blink
// R08: strap low, supply high: charge inhibited, bit set
// R09: strap high, supply low: host pins ignored
// R10: strap high, supply high: full normal operation
// R11: controlled charge needs voltage above minimum
// R12: active calibration freezes cached request, keeps discharge
// R13: both request picks first; none means none
// R14: blink toggles after a register-set count of synchronised scl edges
`timescale 1ns/1ps
`include "bmc_regs.vh"
module bmc_ctrl (
   aclk,
   aresetn,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready,
   irq,
   mode_strap,
   host_bus_supply,
   adapter_present,
   bat_present,
   power_not_good,
   discharge_end_alarm,
   fully_discharged_alarm,
   cond_request,
   bat_charging,
   bat_above_min,
   wake_charge,
   scl_i,
   sda_i,
   sda_o,
   sda_oe_n,
   alert_o,
   alert_oe_n,
   host_bus_en,
   charge_allowed,
   charge_enable,
   charge_start,
   discharge_sel
);
   input  wire        aclk;                   // 100 mhz clock
   input  wire        aresetn;                // sync reset, active low
   input  wire [3:0]  s_axi_awaddr;           // write address
   input  wire        s_axi_awvalid;          // write address valid
   output wire        s_axi_awready;          // write address ready
   input  wire [31:0] s_axi_wdata;            // write data
   input  wire [3:0]  s_axi_wstrb;            // write byte strobes
   input  wire        s_axi_wvalid;           // write data valid
   output wire        s_axi_wready;           // write data ready
   output wire [1:0]  s_axi_bresp;            // write response
   output wire        s_axi_bvalid;           // write response valid
   input  wire        s_axi_bready;           // write response ready
   input  wire [3:0]  s_axi_araddr;           // read address
   input  wire        s_axi_arvalid;          // read address valid
   output wire        s_axi_arready;          // read address ready
   output wire [31:0] s_axi_rdata;            // read data
   output wire [1:0]  s_axi_rresp;            // read response
   output wire        s_axi_rvalid;           // read data valid
   input  wire        s_axi_rready;           // read data ready
   output wire        irq;                    // level interrupt
   input  wire        mode_strap;             // 1: strap at logic_supply
   input  wire        host_bus_supply;        // host bus supply high
   input  wire        adapter_present;        // adapter sensed
   input  wire [1:0]  bat_present;            // battery present
   input  wire        power_not_good;         // power fault flag
   input  wire [1:0]  discharge_end_alarm;    // battery alarm
   input  wire [1:0]  fully_discharged_alarm; // battery empty alarm
   input  wire [1:0]  cond_request;           // reconditioning request
   input  wire [1:0]  bat_charging;           // charger feeds battery
   input  wire [1:0]  bat_above_min;          // above min_charge_voltage
   input  wire [1:0]  wake_charge;            // wake-up charging
   input  wire        scl_i;                  // host clock pin level
   input  wire        sda_i;                  // host data pin level
   output wire        sda_o;                  // data pin drive level
   output wire        sda_oe_n;               // data pin enable, low drives
   output wire        alert_o;                // alert pin drive level
   output wire        alert_oe_n;             // alert pin enable, low drives
   output wire        host_bus_en;            // host bus traffic accepted
   output wire        charge_allowed;         // charging not inhibited
   output wire [1:0]  charge_enable;          // per battery charge permit
   output reg         charge_start;           // pulse: begin charge cycle
   output wire [1:0]  discharge_sel;          // battery being discharged

   ////////////////////////////////////////////////////////////////////////
   // synchronised pin inputs
   wire [13:0] raw_in;  // all asynchronous levels
   wire [13:0] syn_in;  // after two flops
   // scl enters inverted so its synchroniser clears to the idle high level
   assign raw_in = {mode_strap, host_bus_supply, adapter_present,
                    bat_present, power_not_good, discharge_end_alarm,
                    fully_discharged_alarm, cond_request, !scl_i, sda_i};
   genvar gi;
   generate
      for (gi = 0; gi < 14; gi = gi + 1) begin : g_sync
         bmc_sync u_sync (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .async_in (raw_in[gi]),
            .sync_out (syn_in[gi])
         );
      end
   endgenerate
   wire       strap_s  = syn_in[13];      // strap level
   wire       vbus_s   = syn_in[12];      // host bus supply level
   wire       ac_s     = syn_in[11];      // adapter present
   wire [1:0] pres_s   = syn_in[10:9];    // batteries present
   wire       png_s    = syn_in[8];       // power fault
   wire [1:0] dend_s   = syn_in[7:6];     // discharge end alarms
   wire [1:0] full_s   = syn_in[5:4];     // empty alarms
   wire [1:0] creq_s   = syn_in[3:2];     // live requests
   wire       scl_s    = !syn_in[1];      // scl level
   wire       sda_s    = syn_in[0];       // sda level, host traffic only

   ////////////////////////////////////////////////////////////////////////
   // mode decode
   wire indicate = !strap_s && !vbus_s;              // R04
   wire inhibit  = !strap_s &&  vbus_s;              // R08
   assign host_bus_en    = strap_s ? vbus_s : vbus_s; // R09 R10
   assign charge_allowed = !inhibit;                  // R09 R10

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave state
   reg        aw_q, w_q, bvalid_q, rvalid_q; // channel holders
   reg [3:0]  awaddr_q;                      // held write address
   reg [31:0] wdata_q;                       // held write data
   reg [3:0]  wstrb_q;                       // held strobes
   reg [1:0]  bresp_q, rresp_q;              // answers
   reg [31:0] rdata_q;                       // read data
   reg        cal_q;                         // calibration active
   reg [1:0]  sel_q;                         // host chosen battery
   reg [7:0]  blink_div_q;                   // scl edges per phase
   reg [1:0]  cal_bat_q;                     // battery being calibrated
   reg [1:0]  creq_q;                        // cached requests
   reg [2:0]  irq_st_q, irq_mask_q;          // sticky status, mask
   wire       wr_go = aw_q && w_q && !bvalid_q;  // both halves held
   wire       rd_go = s_axi_arvalid && !rvalid_q;
   wire       rd_irq = rd_go && (s_axi_araddr == `BMC_IRQ_OFS);

   assign s_axi_awready = !aw_q && !bvalid_q;
   assign s_axi_wready  = !w_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   ////////////////////////////////////////////////////////////////////////
   // calibration selection and termination
   // pick first battery when both ask, none when neither asks
   wire [1:0] auto_pick = creq_q[0] ? 2'h1 :
                          (creq_q[1] ? 2'h2 : 2'h0);   // R13
   // a host choice of both batteries falls back to the first one
   wire [1:0] want_pick = sel_q[0] ? (creq_q & 2'h1) :
                          (sel_q[1] ? (creq_q & 2'h2) : auto_pick);
   wire host_wr_ctrl = wr_go && (awaddr_q == `BMC_CTRL_OFS) && wstrb_q[0];
   wire host_set  = host_wr_ctrl && wdata_q[`BMC_CTRL_CAL];
   wire host_clr  = host_wr_ctrl && !wdata_q[`BMC_CTRL_CAL];
   wire cal_idx   = cal_bat_q[1];                    // 0 first, 1 second
   wire other     = !cal_idx;
   wire removed   = cal_q && !pres_s[cal_idx];
   wire handoff   = removed && pres_s[other] && creq_s[other];  // R02
   // end on adapter loss, removal, fault, alarms or host zero
   wire cal_end   = cal_q && (!ac_s || removed || png_s ||
                    dend_s[cal_idx] || full_s[cal_idx] || host_clr); // R01

   // calibration flag, battery and frozen request cache
   always @(posedge aclk) begin
      if (!aresetn) begin
         cal_q        <= 1'b0;
         cal_bat_q    <= 2'h0;
         creq_q       <= 2'h0;
         charge_start <= 1'b0;
      end else begin
         charge_start <= 1'b0;
         if (!cal_q)
            creq_q <= creq_s;                        // R12
         if (handoff && !png_s && ac_s && !host_clr) begin
            cal_bat_q <= other ? 2'h2 : 2'h1;        // R02
            creq_q    <= creq_s;
         end else if (cal_end) begin
            cal_q        <= 1'b0;                    // R01
            cal_bat_q    <= 2'h0;
            charge_start <= 1'b1;                    // R03
         end else if (!cal_q && host_set && want_pick != 2'h0 &&
                      ac_s && !png_s) begin
            cal_q     <= 1'b1;
            cal_bat_q <= want_pick;                  // R13
         end
      end
   end
   assign discharge_sel = cal_q ? cal_bat_q : 2'h0;  // R12

   ////////////////////////////////////////////////////////////////////////
   // charge permission per battery
   assign charge_enable = (charge_allowed && ac_s && !cal_q && !png_s) ?
      (pres_s & (bat_above_min | wake_charge)) : 2'h0;  // R11

   ////////////////////////////////////////////////////////////////////////
   // blink generator from synchronised scl rising edges
   reg       scl_d_q;   // delayed scl for edge detect
   reg [7:0] edge_cnt_q;
   reg [7:0] idle_q;    // clocks since scl was last seen low
   reg       blink_q;   // blink phase
   wire      scl_rise = scl_s && !scl_d_q;
   // a long high scl stops blinking; limits how slow the blink clock may be
   always @(posedge aclk) begin
      if (!aresetn) begin
         scl_d_q    <= 1'b1;
         edge_cnt_q <= 8'h00;
         idle_q     <= 8'h00;
         blink_q    <= 1'b1;
      end else begin
         scl_d_q <= scl_s;
         if (!scl_s)
            idle_q <= 8'h00;
         else if (idle_q != `BMC_SCL_IDLE)
            idle_q <= idle_q + 8'h01;
         if (idle_q == `BMC_SCL_IDLE) begin
            edge_cnt_q <= 8'h00;
            blink_q    <= 1'b1;                      // R07 held high
         end else if (scl_rise) begin
            if (edge_cnt_q + 8'h01 >= blink_div_q) begin
               edge_cnt_q <= 8'h00;
               blink_q    <= !blink_q;               // R14
            end else begin
               edge_cnt_q <= edge_cnt_q + 8'h01;
            end
         end
      end
   end

   // status level for one battery
   function stat_lvl;
      input chg, pres, ac, blk;
      begin
         if (!ac || !pres)
            stat_lvl = 1'b1;                         // R05 absent
         else if (chg)
            stat_lvl = 1'b0;                         // R05 charging
         else
            stat_lvl = blk;                          // R05 R07 done
      end
   endfunction
   reg [1:0] stat_q; // registered status levels
   always @(posedge aclk) begin
      if (!aresetn)
         stat_q <= 2'h3;
      else begin
         stat_q[0] <= stat_lvl(bat_charging[0], pres_s[0], ac_s, blink_q);
         stat_q[1] <= stat_lvl(bat_charging[1], pres_s[1], ac_s, blink_q);
      end
   end
   // open drain: drive low when status low in indication mode
   assign sda_o      = 1'b0;
   assign sda_oe_n   = !(indicate && !stat_q[1]);    // R04 R05
   assign alert_o    = 1'b0;
   assign alert_oe_n = indicate ? stat_q[0] : !irq;  // R06 R09

   ////////////////////////////////////////////////////////////////////////
   // interrupts: calibration end, handoff, charge request
   wire [2:0] irq_ev = {charge_start, handoff, cal_end};
   assign irq = |(irq_st_q & irq_mask_q);

   ////////////////////////////////////////////////////////////////////////
   // read mux
   reg [31:0] rd_val; // selected read word
   reg        rd_ok;  // address mapped
   always @* begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      case (s_axi_araddr)
         `BMC_CTRL_OFS: rd_val = {21'h0, blink_div_q, sel_q, cal_q};
         `BMC_STAT_OFS: rd_val = {19'h0, sda_s, inhibit, indicate,
                                  charge_enable, creq_q, cal_bat_q,
                                  pres_s, ac_s, png_s};
         `BMC_IRQ_OFS:  rd_val = {29'h0, irq_st_q};
         `BMC_MASK_OFS: rd_val = {29'h0, irq_mask_q};
         default:       rd_ok  = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // bus channel handling and register writes
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_q        <= 1'b0;
         w_q         <= 1'b0;
         bvalid_q    <= 1'b0;
         rvalid_q    <= 1'b0;
         awaddr_q    <= 4'h0;
         wdata_q     <= 32'h0000_0000;
         wstrb_q     <= 4'h0;
         bresp_q     <= `BMC_RESP_OKAY;
         rresp_q     <= `BMC_RESP_OKAY;
         rdata_q     <= 32'h0000_0000;
         sel_q       <= 2'h0;
         blink_div_q <= `BMC_BLINK_RST;
         irq_st_q    <= 3'h0;
         irq_mask_q  <= `BMC_MASK_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= `BMC_RESP_OKAY;
            case (awaddr_q)
               `BMC_CTRL_OFS: begin
                  // selection locked while calibrating
                  if (wstrb_q[0] && !cal_q)
                     sel_q <= wdata_q[2:1];
                  if (wstrb_q[1] || wstrb_q[0])
                     blink_div_q <= (wdata_q[10:3] == 8'h00) ? 8'h01 :
                                    wdata_q[10:3];
               end
               `BMC_MASK_OFS: if (wstrb_q[0])
                  irq_mask_q <= wdata_q[2:0];
               `BMC_STAT_OFS, `BMC_IRQ_OFS: bresp_q <= `BMC_RESP_OKAY;
               default: bresp_q <= `BMC_RESP_SLVERR;
            endcase
         end else if (bvalid_q && s_axi_bready)
            bvalid_q <= 1'b0;
         if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= rd_ok ? `BMC_RESP_OKAY : `BMC_RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
         // read clears, a fresh event wins
         irq_st_q <= (rd_irq ? 3'h0 : irq_st_q) | irq_ev;
      end
   end
endmodule // bmc_ctrl

/* File: bmc_regs.vh */
// register offsets, field positions, reset values and timing counts for bmc
`ifndef BMC_REGS_VH
`define BMC_REGS_VH
// register byte offsets
`define BMC_CTRL_OFS     4'h0
`define BMC_STAT_OFS     4'h4
`define BMC_IRQ_OFS      4'h8
`define BMC_MASK_OFS     4'hc
// ctrl fields
`define BMC_CTRL_CAL     0
`define BMC_CTRL_SEL_LO  1
`define BMC_CTRL_BLINK   3
// irq fields
`define BMC_IRQ_CALEND   0
`define BMC_IRQ_HANDOFF  1
`define BMC_IRQ_CHGREQ   2
`define BMC_IRQ_W        3
// reset values
`define BMC_CTRL_RST     32'h0000_0000
`define BMC_MASK_RST     3'h0
`define BMC_BLINK_RST    8'h04
// timing counts: scl high this many clocks is taken as tied high
`define BMC_SCL_IDLE     8'hc8
// bus answers
`define BMC_RESP_OKAY    2'h0
`define BMC_RESP_SLVERR  2'h2
`endif

/* File: bmc_sync.v */
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module bmc_sync (
   aclk,
   aresetn,
   async_in,
   sync_out
);
   input  wire aclk;     // system clock
   input  wire aresetn;  // synchronous reset, active low
   input  wire async_in; // level from another domain
   output wire sync_out; // level safe for local logic

   reg meta_q; // first stage, read only by the second
   reg sync_q; // second stage

   // capture in two stages
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // bmc_sync

/* File: bmc_ctrl_chk.sv */
// concurrent checks on the controller ports
`timescale 1ns/1ps
module bmc_ctrl_chk (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       mode_strap,
   input wire logic       host_bus_supply,
   input wire logic       adapter_present,
   input wire logic       power_not_good,
   input wire logic [1:0] bat_charging,
   input wire logic [1:0] bat_above_min,
   input wire logic [1:0] wake_charge,
   input wire logic       sda_o,
   input wire logic       sda_oe_n,
   input wire logic       alert_o,
   input wire logic       alert_oe_n,
   input wire logic       charge_allowed,
   input wire logic [1:0] charge_enable,
   input wire logic       charge_start,
   input wire logic [1:0] discharge_sel
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   //////////////////////////////////////////////////////////////////////
   // indication mode held long enough to pass the input syncs
   sequence s_ind;
      (!mode_strap && !host_bus_supply)[*6];
   endsequence
   property p_open_drain;
      !sda_o && !alert_o;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("pin driven high");
   property p_onehot;
      $onehot0(discharge_sel);
   endproperty
   a_onehot: assert property (p_onehot) else $error("two batteries selected");
   property p_fault_end;
      (power_not_good)[*5] |-> discharge_sel == 2'h0;
   endproperty
   a_fault_end: assert property (p_fault_end) else $error("fault kept discharge");
   property p_ac_end;
      (!adapter_present)[*5] |-> discharge_sel == 2'h0;
   endproperty
   a_ac_end: assert property (p_ac_end) else $error("no adapter, discharging");
   property p_inhibit;
      (!mode_strap && host_bus_supply)[*5] |-> !charge_allowed && !charge_enable;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("charge not inhibited");
   property p_allow;
      (mode_strap)[*5] |-> charge_allowed;
   endproperty
   a_allow: assert property (p_allow) else $error("charge wrongly inhibited");
   property p_min_volt;
      !bat_above_min[0] && !wake_charge[0] |-> !charge_enable[0];
   endproperty
   a_min_volt: assert property (p_min_volt) else $error("low battery charged");
   property p_ind1;
      s_ind and (bat_charging[0])[*6] |-> !alert_oe_n;
   endproperty
   a_ind1: assert property (p_ind1) else $error("first status not low");
   property p_ind2;
      s_ind and (bat_charging[1])[*6] |-> !sda_oe_n;
   endproperty
   a_ind2: assert property (p_ind2) else $error("second status not low");
   property p_start;
      charge_start |-> discharge_sel == 2'h0 ##1 !charge_start;
   endproperty
   a_start: assert property (p_start) else $error("bad charge start pulse");
endmodule // bmc_ctrl_chk
bind bmc_ctrl bmc_ctrl_chk bmc_ctrl_chk_i (
   .aclk, .aresetn, .mode_strap, .host_bus_supply, .adapter_present,
   .power_not_good, .bat_charging, .bat_above_min, .wake_charge, .sda_o,
   .sda_oe_n, .alert_o, .alert_oe_n, .charge_allowed, .charge_enable,
   .charge_start, .discharge_sel);

/* File: bmc_far_model.sv */
// far side: host clock source and pulled-up open-drain data line
`timescale 1ns/1ps
module bmc_far_model #(
   parameter int SCL_HALF = 3 // aclk cycles per scl half period
) (
   input  wire logic aclk,
   input  wire logic scl_run,      // 1: clock runs, 0: held high
   input  wire logic host_off,     // host unpowered, pins float low
   input  wire logic sda_oe_n,     // device pulls data low at 0
   output logic      scl_i = 1'b1, // clock pin level
   output wire logic sda_i         // data pin level
);
   int cnt = 0; // half period counter
   // pull-up wins unless pulled low or the host side is dead
   assign sda_i = (host_off || !sda_oe_n) ? 1'b0 : 1'b1;
   //////////////////////////////////////////////////////////////////////
   // clock toggles while running, rests high when stopped, low with host off
   always @(posedge aclk) begin
      if (host_off) begin
         scl_i <= 1'b0;
      end else if (!scl_run) begin
         scl_i <= 1'b1;
         cnt <= 0;
      end else if (cnt == SCL_HALF - 1) begin
         scl_i <= ~scl_i;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // bmc_far_model

/* File: bmc_ctrl_tb.sv */
// self-checking bench for the calibration and mode controller
`timescale 1ns/1ps
`include "bmc_regs.vh"
module bmc_ctrl_tb;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [3:0]  s_axi_awaddr = 4'h0;
   logic [3:0]  s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        mode_strap = 1'b1;
   logic        host_bus_supply = 1'b1;
   logic        adapter_present = 1'b1;
   logic        power_not_good = 1'b0;
   logic        scl_run = 1'b0;
   logic        host_off = 1'b0;
   logic [1:0]  bat_present = 2'h3;
   logic [1:0]  discharge_end_alarm = 2'h0;
   logic [1:0]  fully_discharged_alarm = 2'h0;
   logic [1:0]  cond_request = 2'h0;
   logic [1:0]  bat_charging = 2'h0;
   logic [1:0]  bat_above_min = 2'h3;
   logic [1:0]  wake_charge = 2'h0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, irq;
   wire         s_axi_arready, s_axi_rvalid, host_bus_en;
   wire  [1:0]  s_axi_bresp, s_axi_rresp, charge_enable, discharge_sel;
   wire  [31:0] s_axi_rdata;
   wire         scl_i, sda_i, sda_o, sda_oe_n, alert_o, alert_oe_n;
   wire         charge_allowed, charge_start;
   integer      errors = 0;
   integer      n_compared = 0;
   integer      tog;
   integer      k;
   bmc_ctrl bmc_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .mode_strap,
      .host_bus_supply, .adapter_present, .bat_present, .power_not_good,
      .discharge_end_alarm, .fully_discharged_alarm, .cond_request,
      .bat_charging, .bat_above_min, .wake_charge, .scl_i, .sda_i, .sda_o,
      .sda_oe_n, .alert_o, .alert_oe_n, .host_bus_en, .charge_allowed,
      .charge_enable, .charge_start, .discharge_sel);
   bmc_far_model bmc_far_model_i (.aclk, .scl_run, .host_off, .sda_oe_n,
      .scl_i, .sda_i);
   // 100 mhz clock
   always #5 aclk = ~aclk;
   //////////////////////////////////////////////////////////////////////
   task cyc(input integer n);
      repeat (n) @(posedge aclk);
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // one write; aw and w offered together, each dropped once taken
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      integer i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50 && !s_axi_bvalid; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      if (i == 50) errors = errors + 1;
      if (i == 50) print_verdict;
      check(s_axi_bresp, r);
   endtask
   // one read, masked and compared
   task rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      integer i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50 && !s_axi_rvalid; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      if (i == 50) errors = errors + 1;
      if (i == 50) print_verdict;
      check(s_axi_rdata & m, e);
      check({30'h0, s_axi_rresp}, {30'h0, `BMC_RESP_OKAY});
   endtask
   // counts level changes of the second status pin
   task blinks(input integer n);
      logic p;
      tog = 0;
      p = sda_oe_n;
      repeat (n) begin
         @(posedge aclk);
         if (sda_oe_n !== p) tog = tog + 1;
         p = sda_oe_n;
      end
   endtask
   //////////////////////////////////////////////////////////////////////
   // hang guard
   initial begin
      #900000;
      errors = errors + 1;
      print_verdict;
   end
   // main sequence
   initial begin
      cyc(3);
      aresetn <= 1'b1;
      rdc(`BMC_CTRL_OFS, 32'hffff_ffff, 32'h0000_0020);
      wr(`BMC_MASK_OFS, 32'h7, `BMC_RESP_OKAY);
      wr(4'h2, 32'h0, `BMC_RESP_SLVERR);
      cond_request <= 2'h3;
      cyc(8);
      wr(`BMC_CTRL_OFS, 32'h21, `BMC_RESP_OKAY);
      cyc(4);
      check(discharge_sel, 2'h1);
      cond_request <= 2'h2;
      cyc(8);
      rdc(`BMC_STAT_OFS, 32'hf0, 32'hd0);
      bat_present <= 2'h2;
      cyc(8);
      check(discharge_sel, 2'h2);
      discharge_end_alarm <= 2'h2;
      cyc(8);
      check(discharge_sel, 2'h0);
      check({irq, alert_oe_n}, 2'h2);
      rdc(`BMC_IRQ_OFS, 32'h7, 32'h7);
      rdc(`BMC_IRQ_OFS, 32'h7, 32'h0);
      wr(`BMC_MASK_OFS, 32'h0, `BMC_RESP_OKAY);
      // adapter loss, fault, empty alarm, removal and host clear each end a calibration, events masked
      for (k = 0; k < 5; k++) begin
         bat_present <= 2'h3;
         discharge_end_alarm <= 2'h0;
         fully_discharged_alarm <= 2'h0;
         adapter_present <= 1'b1;
         power_not_good <= 1'b0;
         cond_request <= 2'h1;
         cyc(8);
         wr(`BMC_CTRL_OFS, 32'h21, `BMC_RESP_OKAY);
         cyc(4);
         check(discharge_sel, 2'h1);
         case (k)
            0: adapter_present <= 1'b0;
            1: power_not_good <= 1'b1;
            2: fully_discharged_alarm <= 2'h1;
            3: bat_present <= 2'h2;
            default: wr(`BMC_CTRL_OFS, 32'h20, `BMC_RESP_OKAY);
         endcase
         cyc(8);
         check({irq, discharge_sel}, 3'h0);
      end
      rdc(`BMC_IRQ_OFS, 32'h1, 32'h1);
      // host picks the second battery although both ask
      cond_request <= 2'h3;
      cyc(8);
      wr(`BMC_CTRL_OFS, 32'h24, `BMC_RESP_OKAY);
      wr(`BMC_CTRL_OFS, 32'h25, `BMC_RESP_OKAY);
      cyc(4);
      check(discharge_sel, 2'h2);
      wr(`BMC_CTRL_OFS, 32'h20, `BMC_RESP_OKAY);
      cond_request <= 2'h0;
      cyc(8);
      wr(`BMC_CTRL_OFS, 32'h21, `BMC_RESP_OKAY);
      cyc(4);
      check(discharge_sel, 2'h0);
      bat_above_min <= 2'h0;
      cyc(2);
      check(charge_enable, 2'h0);
      bat_above_min <= 2'h1;
      wake_charge <= 2'h2;
      cyc(2);
      check(charge_enable, 2'h3);
      mode_strap <= 1'b0;
      cyc(8);
      check({charge_allowed, charge_enable}, 3'h0);
      rdc(`BMC_STAT_OFS, 32'hc00, 32'h800);
      host_bus_supply <= 1'b0;
      bat_charging <= 2'h3;
      cyc(8);
      check({alert_oe_n, sda_oe_n}, 2'h0);
      bat_present <= 2'h1;
      bat_charging <= 2'h0;
      cyc(8);
      check(sda_oe_n, 1'b1);
      rdc(`BMC_STAT_OFS, 32'hc00, 32'h400);
      bat_present <= 2'h3;
      scl_run <= 1'b1;
      cyc(8);
      blinks(150);
      check(tog >= 6 && tog <= 7, 1'b1);
      scl_run <= 1'b0;
      cyc(250);
      blinks(60);
      check({tog[30:0], sda_oe_n}, 32'h1);
      mode_strap <= 1'b1;
      host_off <= 1'b1;
      cyc(8);
      check({host_bus_en, charge_allowed, sda_oe_n}, 3'h3);
      host_off <= 1'b0;
      host_bus_supply <= 1'b1;
      cyc(8);
      check({host_bus_en, charge_allowed}, 2'h3);
      print_verdict;
   end
endmodule // bmc_ctrl_tb
